//--- apr_pkg.sv
// shared constants and types for the converter power and reference control
package apr_pkg;
   // setup byte reference-select field positions
   localparam int SEL_INT_POS  = 2;  // internal_reference_choose_bit
   localparam int SEL_PIN_POS  = 1;  // shared_pin_reference_bit
   localparam int SEL_KEEP_POS = 0;  // reference_keep_on_bit
   localparam logic [2:0] SEL_RESET = 3'h0;  // supply reference, pin is analog input
   // configuration reset values
   localparam logic [3:0] CHAN_RESET    = 4'h0;  // first_analog_channel
   localparam logic [1:0] SCAN_RESET    = 2'h3;  // single channel
   localparam logic       SINGLE_RESET  = 1'b1;  // single-ended
   localparam logic       BIPOLAR_RESET = 1'b0;  // unipolar
   localparam logic       CLKSEL_RESET  = 1'b0;  // internal clock
   // scan limits when the shared pin is a reference
   localparam logic [3:0] LIMIT_SMALL = 4'h2;  // third_analog_channel
   localparam logic [3:0] LIMIT_LARGE = 4'hA;  // eleventh_analog_channel
   localparam logic [1:0] SCAN_UP    = 2'h0;
   localparam logic [1:0] SCAN_UPPER = 2'h2;
   // result width and bipolar offset
   localparam int RES_W = 10;
   localparam logic [9:0] BIP_FLIP = 10'h200;
   // reference wake time
   localparam int REF_WAKE_MS  = 10;
   localparam int CLK_MHZ      = 250;
   localparam int REF_WAKE_CYC = REF_WAKE_MS * 1000 * 1000 / 1000 * CLK_MHZ;

   typedef struct packed {
      logic [2:0] sel;
      logic       clk_ext;
      logic       bipolar;
   } apr_setup_t;

   typedef struct packed {
      logic [1:0] scan;
      logic [3:0] chan;
      logic       single;
   } apr_config_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONVERT,
      ST_HOLD
   } apr_state_t;
endpackage

//--- apr_sync.sv
// two-flop level synchroniser, one per bit
`timescale 1ns/1ps
module apr_sync #(
   parameter int W = 1
) (
   // clock and control
   input  wire logic         clk_in,
   input  wire logic         rstn_in,
   input  wire logic         ce_in,
   // data
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;

   // first stage feeds only the second
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         s1_reg <= '0;
         s2_reg <= '0;
      end else if (ce_in) begin
         s1_reg <= d_in;
         s2_reg <= s1_reg;
      end
   end

   assign q_out = s2_reg;
endmodule

//--- apr_ctrl.sv
// converter power-down, wake-up and reference selection control
`timescale 1ns/1ps
module apr_ctrl #(
   parameter int          NUM_CH       = 12,
   parameter int          REF_WAKE_CYC = apr_pkg::REF_WAKE_CYC,
   parameter int          DEPTH        = 12
) (
   // system clock, reset, enable
   input  wire logic                     REF_CLK_IN,
   input  wire logic                     RSTN_IN,
   input  wire logic                     CE_IN,
   // serial link clock and bus events on it
   input  wire logic                     SCL_CLK_IN,
   input  wire logic                     LINK_ADDR_MATCH_IN,
   input  wire logic                     LINK_STOP_IN,
   input  wire logic                     LINK_NACK_IN,
   // setup and configuration writes
   input  wire logic                     SETUP_WR_IN,
   input  wire apr_pkg::apr_setup_t      SETUP_IN,
   input  wire logic                     CONFIG_WR_IN,
   input  wire apr_pkg::apr_config_t     CONFIG_IN,
   // analog core results
   input  wire logic                     CONV_DONE_IN,
   input  wire logic [9:0]               CONV_RAW_IN,
   input  wire logic                     SCAN_LAST_IN,
   // result read port
   input  wire logic [3:0]               RD_IDX_IN,
   output logic      [9:0]               RD_DATA_OUT,
   output logic                          RD_VALID_OUT,
   // power and reference controls
   output logic                          ANALOG_PWR_OUT,
   output logic                          INTREF_PWR_OUT,
   output logic                          INTREF_READY_OUT,
   output logic                          CONV_GO_OUT,
   output logic                          CONV_CLK_EXT_OUT,
   output logic      [2:0]               ACTIVE_SEL_OUT,
   output logic                          PIN_GROUND_OUT,
   output logic      [3:0]               SCAN_LIMIT_OUT,
   output logic                          SINGLE_ENDED_OUT,
   output logic                          BIPOLAR_OUT,
   output logic      [1:0]               SCAN_MODE_OUT,
   output logic      [3:0]               CHAN_OUT,
   // shared_input_reference_pin drive
   output logic                          SHARED_PIN_REF_OUT,
   output logic                          SHARED_PIN_REF_OE_OUT
);
   apr_pkg::apr_setup_t  setup_reg;
   apr_pkg::apr_config_t config_reg;
   apr_pkg::apr_state_t  state_reg;
   apr_pkg::apr_state_t  state_next;
   logic [2:0]           sel_active_reg;
   logic                 ref_on_reg;
   logic [31:0]          wake_cnt_reg;
   logic [9:0]           mem_reg [DEPTH];
   logic [DEPTH-1:0]     mem_ok_reg;
   logic [3:0]           wr_idx_reg;
   logic [9:0]           rd_data_reg;
   logic                 rd_valid_reg;

   // link-domain event toggles
   logic                 match_tgl_reg;
   logic                 end_tgl_reg;
   logic [1:0]           tgl_sync;
   logic                 match_seen_reg;
   logic                 end_seen_reg;
   wire logic            match_evt;
   wire logic            end_evt;

   // on the bus clock, each event flips a toggle
   always_ff @(posedge SCL_CLK_IN) begin
      if (!RSTN_IN) begin
         match_tgl_reg <= 1'b0;
         end_tgl_reg   <= 1'b0;
      end else begin
         if (LINK_ADDR_MATCH_IN)
            match_tgl_reg <= ~match_tgl_reg;
         if (LINK_STOP_IN || LINK_NACK_IN)
            end_tgl_reg <= ~end_tgl_reg;
      end
   end

   // toggles cross into the system clock
   apr_sync #(.W(2)) u_sync (
      .clk_in  (REF_CLK_IN),
      .rstn_in (RSTN_IN),
      .ce_in   (CE_IN),
      .d_in    ({match_tgl_reg, end_tgl_reg}),
      .q_out   (tgl_sync)
   );

   // edge detection on synchronised toggles
   always_ff @(posedge REF_CLK_IN) begin
      if (!RSTN_IN) begin
         match_seen_reg <= 1'b0;
         end_seen_reg   <= 1'b0;
      end else if (CE_IN) begin
         match_seen_reg <= tgl_sync[1];
         end_seen_reg   <= tgl_sync[0];
      end
   end
   assign match_evt = tgl_sync[1] ^ match_seen_reg;
   assign end_evt   = tgl_sync[0] ^ end_seen_reg;

   // setup and configuration store
   always_ff @(posedge REF_CLK_IN) begin
      if (!RSTN_IN) begin
         setup_reg  <= '{sel: apr_pkg::SEL_RESET, clk_ext: apr_pkg::CLKSEL_RESET,
                        bipolar: apr_pkg::BIPOLAR_RESET};
         config_reg <= '{scan: apr_pkg::SCAN_RESET, chan: apr_pkg::CHAN_RESET,
                        single: apr_pkg::SINGLE_RESET};
      end else if (CE_IN) begin
         if (SETUP_WR_IN)
            setup_reg <= SETUP_IN;
         if (CONFIG_WR_IN)
            config_reg <= CONFIG_IN;
      end
   end

   wire logic ref_want = setup_reg.sel[apr_pkg::SEL_INT_POS] & setup_reg.sel[apr_pkg::SEL_KEEP_POS];

   // reference power follows setup, never the converter state
   always_ff @(posedge REF_CLK_IN) begin
      if (!RSTN_IN) begin
         ref_on_reg   <= 1'b0;
         wake_cnt_reg <= '0;
      end else if (CE_IN) begin
         ref_on_reg <= ref_want;
         if (!ref_want)
            wake_cnt_reg <= '0;
         else if (wake_cnt_reg < 32'(REF_WAKE_CYC))
            wake_cnt_reg <= wake_cnt_reg + 32'h1;
      end
   end

   // converter power state machine
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         apr_pkg::ST_IDLE: begin
            if (match_evt)
               state_next = apr_pkg::ST_CONVERT;
         end
         apr_pkg::ST_CONVERT: begin
            // internal clock stops after last result
            if (!setup_reg.clk_ext && CONV_DONE_IN && SCAN_LAST_IN)
               state_next = apr_pkg::ST_HOLD;
            // external clock waits for bus end
            else if (end_evt)
               state_next = apr_pkg::ST_IDLE;
         end
         apr_pkg::ST_HOLD: begin
            if (end_evt)
               state_next = apr_pkg::ST_IDLE;
            else if (match_evt)
               state_next = apr_pkg::ST_CONVERT;
         end
         default: state_next = apr_pkg::ST_IDLE;
      endcase
   end

   // state register and latched select on conversion start
   always_ff @(posedge REF_CLK_IN) begin
      if (!RSTN_IN) begin
         state_reg      <= apr_pkg::ST_IDLE;
         sel_active_reg <= apr_pkg::SEL_RESET;
      end else if (CE_IN) begin
         state_reg <= state_next;
         // select applies from the next conversion
         if (state_reg != apr_pkg::ST_CONVERT && state_next == apr_pkg::ST_CONVERT)
            sel_active_reg <= setup_reg.sel;
      end
   end

   // result store: contents left uninitialised
   wire logic wr_en = CONV_DONE_IN && state_reg == apr_pkg::ST_CONVERT;
   wire logic [9:0] coded = setup_reg.bipolar ? (CONV_RAW_IN ^ apr_pkg::BIP_FLIP) : CONV_RAW_IN;

   always_ff @(posedge REF_CLK_IN) begin
      if (CE_IN && wr_en)
         mem_reg[wr_idx_reg] <= coded;
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (!RSTN_IN) begin
         mem_ok_reg <= '0;
         wr_idx_reg <= 4'h0;
      end else if (CE_IN) begin
         if (match_evt && state_reg != apr_pkg::ST_CONVERT) begin
            wr_idx_reg <= 4'h0;
            mem_ok_reg <= '0;
         end else if (wr_en) begin
            mem_ok_reg[wr_idx_reg] <= 1'b1;
            wr_idx_reg <= (wr_idx_reg == 4'(DEPTH - 1)) ? 4'h0 : wr_idx_reg + 4'h1;
         end
      end
   end

   // read port registered
   wire logic rd_in_range = 32'(RD_IDX_IN) < DEPTH;
   always_ff @(posedge REF_CLK_IN) begin
      if (!RSTN_IN) begin
         rd_data_reg  <= 10'h000;
         rd_valid_reg <= 1'b0;
      end else if (CE_IN) begin
         rd_valid_reg <= rd_in_range && mem_ok_reg[rd_in_range ? RD_IDX_IN : 4'h0];
         rd_data_reg  <= rd_in_range ? mem_reg[rd_in_range ? RD_IDX_IN : 4'h0] : 10'h000;
      end
   end

   // decoded outputs
   wire logic sel_pin = sel_active_reg[apr_pkg::SEL_PIN_POS];
   wire logic sel_int = sel_active_reg[apr_pkg::SEL_INT_POS];
   wire logic awake   = state_reg == apr_pkg::ST_CONVERT;
   assign ANALOG_PWR_OUT   = awake;
   assign INTREF_PWR_OUT   = ref_on_reg;
   assign INTREF_READY_OUT = ref_on_reg && wake_cnt_reg >= 32'(REF_WAKE_CYC);
   // master owns the internal reference wait
   assign CONV_GO_OUT      = awake;
   assign CONV_CLK_EXT_OUT = setup_reg.clk_ext;
   assign ACTIVE_SEL_OUT   = sel_active_reg;
   // pin as ground in differential reads
   assign PIN_GROUND_OUT   = sel_pin && !config_reg.single;
   wire logic [3:0] top_ch   = (NUM_CH > 4) ? apr_pkg::LIMIT_LARGE : apr_pkg::LIMIT_SMALL;
   wire logic       scanning = config_reg.scan == apr_pkg::SCAN_UP || config_reg.scan == apr_pkg::SCAN_UPPER;
   assign SCAN_LIMIT_OUT   = (sel_pin && scanning && config_reg.single && config_reg.chan > top_ch) ?
                             top_ch : config_reg.chan;
   assign SINGLE_ENDED_OUT = config_reg.single;
   assign BIPOLAR_OUT      = setup_reg.bipolar;
   assign SCAN_MODE_OUT    = config_reg.scan;
   assign CHAN_OUT         = config_reg.chan;
   // drive reference out for upper bits 11
   assign SHARED_PIN_REF_OE_OUT = sel_int && sel_pin && awake;
   assign SHARED_PIN_REF_OUT    = SHARED_PIN_REF_OE_OUT;
   assign RD_DATA_OUT  = rd_data_reg;
   assign RD_VALID_OUT = rd_valid_reg;

   // last internal-clock result of a scan
   sequence s_last_result;
      CE_IN && awake && !setup_reg.clk_ext && CONV_DONE_IN && SCAN_LAST_IN;
   endsequence

   // bus end seen while results are held
   sequence s_hold_end;
      CE_IN && state_reg == apr_pkg::ST_HOLD && end_evt;
   endsequence

   // power and pin drive checks
   a_pin_drive_off: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      !awake |-> !SHARED_PIN_REF_OE_OUT)
      else $error("shared pin driven in shutdown");
   a_pin_drive_on: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      (awake && sel_int && sel_pin) |-> (SHARED_PIN_REF_OE_OUT && SHARED_PIN_REF_OUT))
      else $error("shared pin not driven");
   a_analog_idle: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      state_reg != apr_pkg::ST_CONVERT |-> !ANALOG_PWR_OUT)
      else $error("analog on in idle");

   // reference power checks
   a_ref_follows_set: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      CE_IN |=> ref_on_reg == $past(ref_want))
      else $error("reference power lag");
   a_ref_kept: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      (ref_on_reg && !SETUP_WR_IN && !$past(SETUP_WR_IN)) |=> ref_on_reg)
      else $error("reference dropped without setup write");

   // converter state checks
   a_hold_on_done: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      s_last_result |=> !ANALOG_PWR_OUT)
      else $error("no shutdown after last result");
   a_wake_on_match: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      (CE_IN && state_reg == apr_pkg::ST_IDLE && match_evt) |=> awake)
      else $error("no wake");
   a_wake_from_hold: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      (CE_IN && state_reg == apr_pkg::ST_HOLD && match_evt && !end_evt) |=> awake)
      else $error("no wake from hold");
   a_wake_no_wait: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      (CE_IN && state_reg == apr_pkg::ST_IDLE && match_evt && !setup_reg.sel[apr_pkg::SEL_INT_POS]) |=> CONV_GO_OUT)
      else $error("conversion held after wake");
   a_ext_stays_on: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      (awake && setup_reg.clk_ext && !end_evt) |=> awake)
      else $error("external mode dropped");
   a_hold_ends: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      s_hold_end |=> state_reg == apr_pkg::ST_IDLE)
      else $error("hold kept after bus end");
   a_hold_keeps_ok: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      (state_reg == apr_pkg::ST_HOLD && !match_evt) |=> $stable(mem_ok_reg))
      else $error("results lost in shutdown");

   // select, limiter and result store checks
   a_sel_steady: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      (CE_IN && awake) |=> $stable(sel_active_reg))
      else $error("select changed mid conversion");
   a_sel_latch: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      (CE_IN && !awake && state_next == apr_pkg::ST_CONVERT) |=> sel_active_reg == $past(setup_reg.sel))
      else $error("select not taken at start");
   a_store_marks: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      (CE_IN && wr_en) |=> mem_ok_reg[$past(wr_idx_reg)])
      else $error("stored result not marked");
   a_limit_bound: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      (sel_pin && scanning && config_reg.single) |-> SCAN_LIMIT_OUT <= top_ch)
      else $error("limit");
   a_limit_off: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      !(sel_pin && scanning && config_reg.single) |-> SCAN_LIMIT_OUT == config_reg.chan)
      else $error("limit applied outside reference scans");
   a_bip_code: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      (setup_reg.bipolar && CONV_RAW_IN == 10'h200) |-> coded == 10'h000)
      else $error("coding");
   a_uni_code: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
      !setup_reg.bipolar |-> coded == CONV_RAW_IN)
      else $error("unipolar coding");
endmodule

//--- apr_master.sv
// two-wire bus master model: link clock and bus events
`timescale 1ns/1ps
module apr_master (
   // link clock, rests low between frames
   output logic scl_out,
   // bus events, one link cycle each
   output logic match_out,
   output logic stop_out,
   output logic nack_out
);
   // idle levels at time zero
   initial begin
      scl_out = 1'b0;
      match_out = 1'b0;
      stop_out = 1'b0;
      nack_out = 1'b0;
   end

   // one link cycle of 125 ns
   task automatic tick();
      #62.5 scl_out = 1'b1;
      #62.5 scl_out = 1'b0;
   endtask

   task automatic run(input int n);
      repeat (n) tick();
   endtask

   // frame with one event: 0 address match, 1 stop or restart, 2 nack
   // lead sets how slowly the event follows the frame start
   // session ended by stop or nack
   task automatic send(input int kind, input int lead);
      run(lead);
      match_out = (kind == 0);
      stop_out = (kind == 1);
      nack_out = (kind == 2);
      tick();
      match_out = 1'b0;
      stop_out = 1'b0;
      nack_out = 1'b0;
      run(2);
   endtask
endmodule

//--- adc_power_reference_control_tb.sv
// self-checking bench for the power and reference control
`timescale 1ns/1ps
module adc_power_reference_control_tb;
   logic                 ref_clk = 1'b0;
   logic                 rstn = 1'b0;
   logic                 setup_wr = 1'b0;
   logic                 cfg_wr = 1'b0;
   logic                 done = 1'b0;
   logic                 last = 1'b0;
   logic [9:0]           raw = 10'h000;
   logic [3:0]           rd_idx = 4'h0;
   apr_pkg::apr_setup_t  setup = '0;
   apr_pkg::apr_config_t cfg = '0;
   logic [9:0]           rd_data;
   logic [3:0]           lim, chan;
   logic [2:0]           asel;
   logic [1:0]           smode;
   logic                 scl, match, stop, nack, valid, apwr, rpwr, rrdy;
   logic                 go, cext, pgnd, se, bip, pin, pin_oe;
   int                   errors = 0;
   int                   checks = 0;

   // system clock, 4 ns
   always #2 ref_clk = ~ref_clk;

   apr_master m (.scl_out(scl), .match_out(match), .stop_out(stop), .nack_out(nack));

   apr_ctrl #(.NUM_CH(12), .REF_WAKE_CYC(20), .DEPTH(12)) dut (
      .REF_CLK_IN(ref_clk), .RSTN_IN(rstn), .CE_IN(1'b1), .SCL_CLK_IN(scl),
      .LINK_ADDR_MATCH_IN(match), .LINK_STOP_IN(stop), .LINK_NACK_IN(nack),
      .SETUP_WR_IN(setup_wr), .SETUP_IN(setup), .CONFIG_WR_IN(cfg_wr), .CONFIG_IN(cfg),
      .CONV_DONE_IN(done), .CONV_RAW_IN(raw), .SCAN_LAST_IN(last), .RD_IDX_IN(rd_idx),
      .RD_DATA_OUT(rd_data), .RD_VALID_OUT(valid), .ANALOG_PWR_OUT(apwr),
      .INTREF_PWR_OUT(rpwr), .INTREF_READY_OUT(rrdy), .CONV_GO_OUT(go),
      .CONV_CLK_EXT_OUT(cext), .ACTIVE_SEL_OUT(asel), .PIN_GROUND_OUT(pgnd),
      .SCAN_LIMIT_OUT(lim), .SINGLE_ENDED_OUT(se), .BIPOLAR_OUT(bip),
      .SCAN_MODE_OUT(smode), .CHAN_OUT(chan), .SHARED_PIN_REF_OUT(pin),
      .SHARED_PIN_REF_OE_OUT(pin_oe)
   );

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic wr_setup(input logic [2:0] s, input logic e, input logic b);
      @(negedge ref_clk);
      setup = '{sel: s, clk_ext: e, bipolar: b};
      setup_wr = 1'b1;
      @(negedge ref_clk);
      setup_wr = 1'b0;
      @(negedge ref_clk);
   endtask

   task automatic wr_cfg(input logic [1:0] sc, input logic [3:0] ch, input logic sg);
      @(negedge ref_clk);
      cfg = '{scan: sc, chan: ch, single: sg};
      cfg_wr = 1'b1;
      @(negedge ref_clk);
      cfg_wr = 1'b0;
      @(negedge ref_clk);
   endtask

   // address match, then a bounded wait for power-up
   task automatic start(input int lead);
      int n;
      n = 0;
      m.send(0, lead);
      @(negedge ref_clk);
      while (apwr !== 1'b1 && n < 40) begin
         @(negedge ref_clk);
         n++;
      end
      chk(apwr, 1'b1);
   endtask

   // one result from the analog core, then one settle cycle
   task automatic put(input logic [9:0] r, input logic l);
      @(negedge ref_clk);
      raw = r;
      last = l;
      done = 1'b1;
      @(negedge ref_clk);
      done = 1'b0;
      last = 1'b0;
      @(negedge ref_clk);
   endtask

   task automatic rd(input logic [3:0] i, input logic [9:0] d, input logic v);
      @(negedge ref_clk);
      rd_idx = i;
      @(negedge ref_clk);
      chk(valid, v);
      if (v)
         chk(rd_data, d);
   endtask

   // watchdog: the tests need about 8 us
   initial begin
      #40000;
      errors++;
      end_sim();
   end

   // main test sequence
   initial begin
      fork
         repeat (4) @(posedge ref_clk);
         m.run(4);
      join
      @(negedge ref_clk);
      rstn = 1'b1;
      @(negedge ref_clk);
      chk({se, bip, smode, chan, cext, asel, apwr, rpwr, pin_oe}, 15'h5800);
      wr_setup(3'h0, 1'b0, 1'b0);
      start(1);
      chk(go, 1'b1);
      put(10'h3FF, 1'b0);
      put(10'h155, 1'b1);
      chk(apwr, 1'b0);
      rd(4'h0, 10'h3FF, 1'b1);
      rd(4'h1, 10'h155, 1'b1);
      rd(4'hC, 10'h000, 1'b0);
      m.send(1, 2);
      wr_setup(3'h0, 1'b0, 1'b1);
      start(3);
      put(10'h005, 1'b1);
      rd(4'h0, 10'h205, 1'b1);
      rd(4'h1, 10'h000, 1'b0);
      m.send(2, 1);
      wr_setup(3'h0, 1'b1, 1'b0);
      chk(cext, 1'b1);
      start(1);
      put(10'h001, 1'b1);
      chk(apwr, 1'b1);
      m.send(2, 1);
      chk(apwr, 1'b0);
      for (int s = 0; s < 8; s++) begin
         wr_setup(s[2:0], 1'b0, 1'b0);
         chk(rpwr, s[2] & s[0]);
      end
      chk(rrdy, 1'b0);
      chk(pin_oe, 1'b0);
      chk(asel, 3'h0);
      repeat (24) @(negedge ref_clk);
      chk(rrdy, 1'b1);
      wr_cfg(2'h0, 4'hB, 1'b1);
      start(2);
      chk(asel, 3'h7);
      chk(pin_oe, 1'b1);
      chk(pin, 1'b1);
      chk(lim, apr_pkg::LIMIT_LARGE);
      put(10'h000, 1'b1);
      chk(pin_oe, 1'b0);
      m.send(1, 1);
      chk(rpwr, 1'b1);
      wr_setup(3'h4, 1'b0, 1'b0);
      wr_cfg(2'h3, 4'hB, 1'b0);
      start(1);
      chk(pin_oe, 1'b0);
      chk(pgnd, 1'b0);
      put(10'h000, 1'b1);
      m.send(1, 1);
      wr_setup(3'h2, 1'b0, 1'b0);
      start(1);
      chk(pgnd, 1'b1);
      chk(asel, 3'h2);
      put(10'h000, 1'b1);
      m.send(1, 1);
      end_sim();
   end
endmodule
